//--- common/timer_consts.svh
// Purpose: offsets, field positions, reset values and limits of the timer
// Assumes: word aligned APB registers, byte offsets below
// Notes: definitions only
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

`define OFS_CTL 8'h00
`define OFS_CLK 8'h04
`define OFS_TC 8'h08
`define OFS_CCCTL 8'h0C
`define OFS_CCA 8'h10
`define OFS_CCB 8'h14
`define OFS_FLAGS 8'h18
`define OFS_IEN 8'h1C

`define CTL_RUN 0
`define CTL_CLEAR 1
`define CTL_MODE 2
`define CTL_BUFEN 3
`define CTL_HALF 4

`define CLK_SRC_LSB 0
`define CLK_DIV_LSB 4
`define CLK_GATE 8

`define CC_A_MODE 0
`define CC_B_MODE 1
`define CC_TRG_A_LSB 4
`define CC_TRG_B_LSB 6
`define CC_OUT_A_LSB 8
`define CC_OUT_B_LSB 10

`define FLAG_CMP_A 0
`define FLAG_CMP_B 1
`define FLAG_CAP_A 2
`define FLAG_CAP_B 3
`define FLAG_OVW_A 4
`define FLAG_OVW_B 5

`define DIV_MAX_LS 4'h8
`define DIV_RESERVED 4'hF
`define TRG_RISE 0
`define TRG_FALL 1
`define STATE_RST '0

`endif

//--- common/timer_pkg.sv
// Purpose: types of the compare/capture timer
// Assumes: constants come from timer_consts.svh
// Notes: the whole module state is one packed struct
package timer_pkg;

	typedef enum logic [1:0]
	{
		SRC_HS = 2'b00,
		SRC_LS = 2'b01,
		SRC_RSV = 2'b10,
		SRC_EXT = 2'b11
	} clk_src_t;

	typedef struct packed
	{
		logic [4:0] sy1;
		logic [4:0] sy2;
		logic [4:0] sy3;
		logic [13:0] div_cnt;
		logic run;
		logic count_mode;
		logic buf_en;
		logic half;
		logic [1:0] src;
		logic [3:0] div;
		logic gate;
		logic a_mode;
		logic b_mode;
		logic [1:0] trg_a;
		logic [1:0] trg_b;
		logic [1:0] out_a;
		logic [1:0] out_b;
		logic [15:0] cca;
		logic [15:0] ccb;
		logic [15:0] bufa;
		logic [15:0] bufb;
		logic [15:0] tc;
		logic [16:0] dual;
		logic [5:0] flags;
		logic [5:0] ien;
		logic cmp_a_p;
		logic cmp_b_p;
		logic [31:0] prdata;
		logic pslverr;
	} timer_state_t;

endpackage

//--- design/pwm_compare_capture_timer.sv
// Purpose: one channel of a 16-bit up counter with two compare/capture regs
// Assumes: oscillator, external clock and trigger pins are asynchronous
// Notes: APB slave with zero wait states; waveform shaping lives outside
// Summary of operation
// - source code 3 external pin, 1 low-speed, 0 high-speed, 2 reserved
// - internal divider code n below 15 divides by 2^n, code 15 stops the count; low-speed capped at 1/256
// - clock gate bit resets to 0 and blocks the count clock
// - each compare/capture register has a mode bit, 0 compare, 1 capture
// - counter equal to compare A pulses compare A and sets its flag
// - counter equal to compare B pulses, sets flag, clears counter
// - compare event for value V comes V+1 count clocks after zero
// - buffer enable compares against copies loaded on compare B
// - edge select 3 both, 2 falling, 1 rising, 0 off
// - selected edge while running captures counter, sets capture flag
// - capture with flag still set overwrites and sets overwrite flag
// - edge selection has no effect in comparator mode
// - a register in capture mode produces no compare signal
// - mode 0 repeats, counter wraps through zero and keeps running
// - mode 1 one-shot stops counter when compare B occurs
// - half clock bit matches compare A against a dual-edge counter
// - dual-edge counter is not readable
// - run 1 starts counting, run 0 holds the counter value
// - clear bit zeroes counter; run and clear together start from zero
`timescale 1ns/1ps
`default_nettype none
`include "timer_consts.svh"

module pwm_compare_capture_timer
	import timer_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic high_speed_osc,
	input wire logic low_speed_osc,
	input wire logic ext_count_clock_pin,
	input wire logic trigger_a_pin,
	input wire logic trigger_b_pin,
	output logic compare_a,
	output logic compare_b,
	output logic [1:0] output_a_mode,
	output logic [1:0] output_b_mode,
	output logic irq_request
);

	timer_state_t s_r;
	timer_state_t s_nxt;
	logic [4:0] rise;
	logic [4:0] fall;
	logic [3:0] dn;
	logic [13:0] mask;
	logic [13:0] hmask;
	logic srise;
	logic sfall;
	logic internal;
	logic full;
	logic half_ev;
	logic tick;
	logic htick;
	logic [15:0] cmpa_v;
	logic [15:0] cmpb_v;
	logic ev_a;
	logic ev_b;
	logic cap_a;
	logic cap_b;
	logic wr;
	logic clr_wr;
	logic [5:0] set_f;
	logic [31:0] rdata;
	logic hit;

	assign pready = 1'b1;
	assign prdata = s_r.prdata;
	assign pslverr = s_r.pslverr;
	assign compare_a = s_r.cmp_a_p;
	assign compare_b = s_r.cmp_b_p;
	assign output_a_mode = s_r.out_a;
	assign output_b_mode = s_r.out_b;
	assign irq_request = |(s_r.flags & s_r.ien);

	always_comb
	begin
		s_nxt = s_r;
		// pins pass two flops; sy3 only feeds edge detection
		s_nxt.sy1 = {trigger_b_pin, trigger_a_pin, ext_count_clock_pin,
			low_speed_osc, high_speed_osc};
		s_nxt.sy2 = s_r.sy1;
		s_nxt.sy3 = s_r.sy2;
		rise = s_r.sy2 & ~s_r.sy3;
		fall = ~s_r.sy2 & s_r.sy3;

		// low-speed codes above 1/256 are clamped rather than left undefined
		dn = s_r.div;
		if (s_r.src == SRC_LS && dn > `DIV_MAX_LS)
			dn = `DIV_MAX_LS;
		mask = 14'((15'h0001 << dn) - 15'h0001);
		hmask = mask >> 1;

		srise = 1'b0;
		sfall = 1'b0;
		internal = 1'b0;
		case (clk_src_t'(s_r.src))
			SRC_HS:
			begin
				srise = rise[0];
				sfall = fall[0];
				internal = 1'b1;
			end
			SRC_LS:
			begin
				srise = rise[1];
				sfall = fall[1];
				internal = 1'b1;
			end
			SRC_EXT:
			begin
				srise = rise[2];
				sfall = fall[2];
			end
			default:
			begin
				srise = 1'b0;
				sfall = 1'b0;
			end
		endcase

		// half_ev marks both edges of the divided count clock
		if (internal)
		begin
			full = (s_r.div != `DIV_RESERVED) && srise &&
				(&(s_r.div_cnt | ~mask));
			if (dn == 4'h0)
				half_ev = (s_r.div != `DIV_RESERVED) && (srise || sfall);
			else
				half_ev = (s_r.div != `DIV_RESERVED) && srise &&
					(&(s_r.div_cnt | ~hmask));
			if (srise)
				s_nxt.div_cnt = s_r.div_cnt + 14'h0001;
		end
		else
		begin
			full = srise;
			half_ev = srise || sfall;
		end

		tick = s_r.gate && s_r.run && full;
		htick = s_r.gate && s_r.run && half_ev;

		cmpa_v = s_r.buf_en ? s_r.bufa : s_r.cca;
		cmpb_v = s_r.buf_en ? s_r.bufb : s_r.ccb;
		ev_b = tick && !s_r.b_mode && (s_r.tc == cmpb_v);
		if (s_r.half)
			ev_a = htick && !s_r.a_mode &&
				(s_r.dual == {1'b0, cmpa_v});
		else
			ev_a = tick && !s_r.a_mode && (s_r.tc == cmpa_v);
		s_nxt.cmp_a_p = ev_a;
		s_nxt.cmp_b_p = ev_b;

		// counter wraps naturally on overflow in repeat mode
		if (tick)
			s_nxt.tc = ev_b ? 16'h0000 : s_r.tc + 16'h0001;
		if (ev_b)
			s_nxt.dual = 17'h0_0000;
		else if (htick)
			s_nxt.dual = s_r.dual + 17'h0_0001;

		// with buffering off the copies follow so enabling starts clean
		if (!s_r.buf_en || ev_b)
		begin
			s_nxt.bufa = s_r.cca;
			s_nxt.bufb = s_r.ccb;
		end

		wr = psel && penable && pwrite;
		clr_wr = wr && paddr == `OFS_CTL && pwdata[`CTL_CLEAR];
		if (wr)
		begin
			case (paddr)
				`OFS_CTL:
				begin
					s_nxt.run = pwdata[`CTL_RUN];
					s_nxt.count_mode = pwdata[`CTL_MODE];
					s_nxt.buf_en = pwdata[`CTL_BUFEN];
					s_nxt.half = pwdata[`CTL_HALF];
				end
				`OFS_CLK:
				begin
					s_nxt.src = pwdata[`CLK_SRC_LSB +: 2];
					s_nxt.div = pwdata[`CLK_DIV_LSB +: 4];
					s_nxt.gate = pwdata[`CLK_GATE];
				end
				`OFS_CCCTL:
				begin
					s_nxt.a_mode = pwdata[`CC_A_MODE];
					s_nxt.b_mode = pwdata[`CC_B_MODE];
					s_nxt.trg_a = pwdata[`CC_TRG_A_LSB +: 2];
					s_nxt.trg_b = pwdata[`CC_TRG_B_LSB +: 2];
					s_nxt.out_a = pwdata[`CC_OUT_A_LSB +: 2];
					s_nxt.out_b = pwdata[`CC_OUT_B_LSB +: 2];
				end
				`OFS_CCA: s_nxt.cca = pwdata[15:0];
				`OFS_CCB: s_nxt.ccb = pwdata[15:0];
				`OFS_IEN: s_nxt.ien = pwdata[5:0];
				default: s_nxt.ien = s_r.ien;
			endcase
		end
		if (clr_wr)
		begin
			s_nxt.tc = 16'h0000;
			s_nxt.dual = 17'h0_0000;
		end
		if (ev_b && s_r.count_mode)
			s_nxt.run = 1'b0;

		cap_a = s_r.a_mode && s_r.run &&
			((s_r.trg_a[`TRG_RISE] && rise[3]) ||
			(s_r.trg_a[`TRG_FALL] && fall[3]));
		cap_b = s_r.b_mode && s_r.run &&
			((s_r.trg_b[`TRG_RISE] && rise[4]) ||
			(s_r.trg_b[`TRG_FALL] && fall[4]));
		if (cap_a)
			s_nxt.cca = s_r.tc;
		if (cap_b)
			s_nxt.ccb = s_r.tc;

		set_f = {cap_b && s_r.flags[`FLAG_CAP_B],
			cap_a && s_r.flags[`FLAG_CAP_A], cap_b, cap_a, ev_b, ev_a};
		// a hardware set in the same cycle as a write-one clear wins
		if (wr && paddr == `OFS_FLAGS)
			s_nxt.flags = (s_r.flags & ~pwdata[5:0]) | set_f;
		else
			s_nxt.flags = s_r.flags | set_f;

		hit = 1'b1;
		rdata = 32'h0000_0000;
		case (paddr)
			`OFS_CTL: rdata[4:0] = {s_r.half, s_r.buf_en, s_r.count_mode,
				1'b0, s_r.run};
			`OFS_CLK: rdata[8:0] = {s_r.gate, s_r.div, 2'b00, s_r.src};
			`OFS_TC: rdata[15:0] = s_r.tc;
			`OFS_CCCTL: rdata[11:0] = {s_r.out_b, s_r.out_a, s_r.trg_b,
				s_r.trg_a, 2'b00, s_r.b_mode, s_r.a_mode};
			`OFS_CCA: rdata[15:0] = s_r.cca;
			`OFS_CCB: rdata[15:0] = s_r.ccb;
			`OFS_FLAGS: rdata[5:0] = s_r.flags;
			`OFS_IEN: rdata[5:0] = s_r.ien;
			default: hit = 1'b0;
		endcase
		if (psel && !penable)
		begin
			s_nxt.prdata = pwrite ? 32'h0000_0000 : rdata;
			s_nxt.pslverr = !hit;
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			s_r <= `STATE_RST;
		else
			s_r <= s_nxt;
	end

	a_gate_blocks: assert property (@(posedge clk) disable iff (!reset_n)
		!s_r.gate && !clr_wr |=> $stable(s_r.tc))
		else $error("counter moved with clock gate closed");

	a_stop_holds: assert property (@(posedge clk) disable iff (!reset_n)
		!s_r.run && !clr_wr |=> $stable(s_r.tc))
		else $error("counter moved while stopped");

	a_reserved_src: assert property (@(posedge clk) disable iff (!reset_n)
		s_r.src == SRC_RSV && !clr_wr |=> $stable(s_r.tc))
		else $error("reserved source advanced the counter");

	a_clear_zero: assert property (@(posedge clk) disable iff (!reset_n)
		clr_wr |=> s_r.tc == 16'h0000 && s_r.dual == 17'h0_0000)
		else $error("clear write did not zero the counter");

	a_cmpb_effects: assert property (@(posedge clk) disable iff (!reset_n)
		s_r.cmp_b_p |-> s_r.tc == 16'h0000 && s_r.flags[`FLAG_CMP_B])
		else $error("compare B without counter clear or flag");

	a_oneshot_stop: assert property (@(posedge clk) disable iff (!reset_n)
		s_r.cmp_b_p && $past(s_r.count_mode) |-> !s_r.run)
		else $error("one-shot counter kept running");

	a_capture_quiet: assert property (@(posedge clk) disable iff (!reset_n)
		$past(s_r.a_mode) |-> !s_r.cmp_a_p)
		else $error("compare A from a register in capture mode");

	a_capture_load: assert property (@(posedge clk) disable iff (!reset_n)
		cap_a |=> s_r.cca == $past(s_r.tc) && s_r.flags[`FLAG_CAP_A])
		else $error("capture A did not load the counter");

	a_overwrite_flag: assert property (@(posedge clk) disable iff (!reset_n)
		cap_b && s_r.flags[`FLAG_CAP_B] |=> s_r.flags[`FLAG_OVW_B])
		else $error("overwrite of capture B not flagged");

	a_compare_no_cap: assert property (@(posedge clk) disable iff (!reset_n)
		!s_r.b_mode && !(wr && paddr == `OFS_CCB) |=> $stable(s_r.ccb))
		else $error("comparator register changed by a trigger");

endmodule
`default_nettype wire

//--- tb/pin_model.sv
// Purpose: far side pins: oscillators, external count clock, triggers
// Assumes: every pin changes by nonblocking assignment after a clk edge
// Notes: each level is held at least 3 clk so 2-flop sampling never misses it
`timescale 1ns/1ps
`default_nettype none
module pin_model
#(
	// oscillator half periods in clk cycles; the bench reckons gaps from them
	parameter int HS_HALF = 3,
	parameter int LS_HALF = 7
)
(
	input wire logic clk,
	output logic hs_osc,
	output logic ls_osc,
	output logic ext_clk,
	output logic trg_a,
	output logic trg_b
);
	int n = 0;
	initial
	begin
		{hs_osc, ls_osc, ext_clk, trg_a, trg_b} = 5'h00;
	end
	always @(posedge clk)
	begin
		n <= n + 1;
		if (n % HS_HALF == 0)
			hs_osc <= ~hs_osc;
		if (n % LS_HALF == 0)
			ls_osc <= ~ls_osc;
	end
	// s picks {ext_clk, trg_a, trg_b}; the pins rest between calls
	task automatic flip(input logic [2:0] s, input int k);
		repeat (k)
		begin
			repeat (3) @(posedge clk);
			{ext_clk, trg_a, trg_b} <= {ext_clk, trg_a, trg_b} ^ s;
		end
		// sync, edge detect and compare pulse must land before a check
		repeat (6) @(posedge clk);
	endtask
endmodule
`default_nettype wire

//--- tb/pwm_compare_capture_timer_test.sv
// Purpose: self-checking bench for the compare/capture timer
// Assumes: zero wait APB slave; counting driven from the external pin, and from the oscillators in the divider gap checks
// Notes: expected read data is queued by the driver and checked by a monitor
`timescale 1ns/1ps
`default_nettype none
`include "timer_consts.svh"
module pwm_compare_capture_timer_test;
	logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic pready, pslverr, hs, ls, ext, ta, tb, ca, cb, irq, m;
	logic [1:0] c, oa, ob;
	logic [32:0] exp_q[$];
	int n_errors = 0, cmp_count = 0, na = 0, nb = 0, cyc = 0, k;
	int gap = 0, last_b = 0, e_gap = 0;
	int seed = 32'h4764_3441;
	logic [15:0] v;
	localparam int HS_HALF = 3;
	localparam int LS_HALF = 7;
	always #10 clk = ~clk;
	pwm_compare_capture_timer pwm_compare_capture_timer_i (.clk(clk),
		.reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .high_speed_osc(hs),
		.low_speed_osc(ls), .ext_count_clock_pin(ext),
		.trigger_a_pin(ta), .trigger_b_pin(tb), .compare_a(ca),
		.compare_b(cb), .output_a_mode(oa), .output_b_mode(ob),
		.irq_request(irq));
	pin_model #(.HS_HALF(HS_HALF), .LS_HALF(LS_HALF)) pin_model_i (.clk(clk),
		.hs_osc(hs), .ls_osc(ls), .ext_clk(ext), .trg_a(ta), .trg_b(tb));
	task automatic report_and_stop();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [32:0] got, input logic [32:0] e);
		cmp_count++;
		if (got !== e)
		begin
			$display("[ERR] t=%0t got %h exp %h", $time, got, e);
			n_errors++;
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic er = 1'b0);
		exp_q.push_back({er, e});
		apb(1'b0, a, 32'h0000_0000);
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cb === 1'b1)
		begin
			nb++;
			gap = cyc - last_b;
			last_b = cyc;
		end
		if (ca === 1'b1)
			na++;
		if (psel && penable && pready && !pwrite)
			chk({pslverr, prdata}, exp_q.pop_front());
		if (cyc == 20000)
		begin
			n_errors++;
			report_and_stop();
		end
	end
	initial
	begin
		v = 16'({$random(seed)} % 3 + 2);
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		rd(`OFS_CLK, 32'h0000_0000);
		rd(`OFS_CCCTL, 32'h0000_0000);
		rd(`OFS_CTL, 32'h0000_0000);
		rd(8'h20, 32'h0000_0000, 1'b1);
		wr(`OFS_CCA, 32'h0000_0001);
		wr(`OFS_CCB, {16'h0000, v});
		wr(`OFS_IEN, 32'h0000_0002);
		wr(`OFS_CLK, 32'h0000_0003);
		wr(`OFS_CTL, 32'h0000_0003);
		pin_model_i.flip(3'b100, 8);
		rd(`OFS_TC, 32'h0000_0000);
		wr(`OFS_CTL, 32'h0000_0000);
		wr(`OFS_CLK, 32'h0000_0103);
		wr(`OFS_CTL, 32'h0000_0003);
		pin_model_i.flip(3'b100, 2 * v);
		chk(33'(nb), 33'h0_0000_0000);
		chk(33'(na), 33'h0_0000_0001);
		pin_model_i.flip(3'b100, 2);
		chk(33'(nb), 33'h0_0000_0001);
		rd(`OFS_TC, 32'h0000_0000);
		rd(`OFS_FLAGS, 32'h0000_0003);
		chk(33'(irq), 33'h0_0000_0001);
		wr(`OFS_FLAGS, 32'h0000_0003);
		chk(33'(irq), 33'h0_0000_0000);
		pin_model_i.flip(3'b100, 2 * v + 2);
		chk(33'(nb), 33'h0_0000_0002);
		wr(`OFS_CTL, 32'h0000_0007);
		pin_model_i.flip(3'b100, 2 * v + 8);
		chk(33'(nb), 33'h0_0000_0003);
		rd(`OFS_TC, 32'h0000_0000);
		wr(`OFS_CCB, 32'h0000_00FF);
		wr(`OFS_CTL, 32'h0000_0003);
		pin_model_i.flip(3'b100, 4);
		wr(`OFS_CTL, 32'h0000_0000);
		pin_model_i.flip(3'b100, 4);
		rd(`OFS_TC, 32'h0000_0002);
		wr(`OFS_CTL, 32'h0000_0001);
		pin_model_i.flip(3'b100, 2);
		rd(`OFS_TC, 32'h0000_0003);
		wr(`OFS_FLAGS, 32'h0000_003F);
		wr(`OFS_CCCTL, 32'h0000_0011);
		k = na;
		pin_model_i.flip(3'b010, 2);
		pin_model_i.flip(3'b100, 2);
		pin_model_i.flip(3'b010, 2);
		pin_model_i.flip(3'b100, 4);
		rd(`OFS_CCA, 32'h0000_0004);
		rd(`OFS_FLAGS, 32'h0000_0014);
		chk(33'(na), 33'(k));
		// last pass puts register b back in comparator mode with both edges
		for (int i = 0; i < 5; i++)
		begin
			m = (i < 4);
			c = (i == 4) ? 2'h3 : 2'(i);
			wr(`OFS_FLAGS, 32'h0000_003F);
			wr(`OFS_CCCTL, {24'h00_0000, c, 4'h0, m, 1'b1});
			pin_model_i.flip(3'b001, 2);
			rd(`OFS_FLAGS, {26'h0, m && c == 2'h3, 1'b0,
				m && c != 2'h0, 3'h0});
		end
		for (int i = 0; i < 2; i++)
		begin
			wr(`OFS_CTL, 32'h0000_0000);
			wr(`OFS_CLK, (i == 0) ? 32'h0000_0102 : 32'h0000_01F0);
			wr(`OFS_CTL, 32'h0000_0003);
			pin_model_i.flip(3'b100, 8);
			rd(`OFS_TC, 32'h0000_0000);
		end
		// compare B at every tick: the second gap is the divided period
		wr(`OFS_CTL, 32'h0000_0000);
		wr(`OFS_CCB, 32'h0000_0000);
		for (int i = 0; i < 2; i++)
		begin
			wr(`OFS_CLK, (i == 0) ? 32'h0000_0130 : 32'h0000_0181);
			wr(`OFS_CTL, 32'h0000_0003);
			e_gap = (i == 0) ? 2 * HS_HALF * 8 : 2 * LS_HALF * 256;
			k = nb;
			while (nb < k + 2)
				@(posedge clk);
			chk(33'(gap), 33'(e_gap));
			wr(`OFS_CTL, 32'h0000_0000);
		end
		// half clock: compare A on the fourth edge, not the fourth rise
		wr(`OFS_CLK, 32'h0000_0103);
		wr(`OFS_CCCTL, 32'h0000_0500);
		chk(33'({oa, ob}), 33'h0_0000_0005);
		wr(`OFS_CCA, 32'h0000_0003);
		pin_model_i.flip(3'b100, 2);
		wr(`OFS_CCB, 32'h0000_0005);
		wr(`OFS_CTL, 32'h0000_0013);
		k = na;
		pin_model_i.flip(3'b100, 3);
		chk(33'(na), 33'(k));
		pin_model_i.flip(3'b100, 1);
		chk(33'(na), 33'(k + 1));
		// buffered compare B keeps the old value until compare B reloads it
		wr(`OFS_CTL, 32'h0000_000B);
		wr(`OFS_CCB, 32'h0000_0001);
		k = nb;
		pin_model_i.flip(3'b100, 4);
		chk(33'(nb), 33'(k));
		pin_model_i.flip(3'b100, 8);
		chk(33'(nb), 33'(k + 1));
		pin_model_i.flip(3'b100, 4);
		chk(33'(nb), 33'(k + 2));
		// reset in mid-run returns the registers to zero
		reset_n <= 1'b0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		chk(33'(irq), 33'h0_0000_0000);
		rd(`OFS_CLK, 32'h0000_0000);
		rd(`OFS_CCCTL, 32'h0000_0000);
		report_and_stop();
	end
endmodule
`default_nettype wire
